// ===== src/bsrc_pkg.sv
package bsrc_pkg;

	// ==========================================================
	// register map
	localparam logic [15:0] CPU_CLOCK_DIVIDER_OFS   = 16'hC008;
	localparam logic [15:0] POWER_SLEEP_CONTROL_OFS = 16'hC00A;
	localparam logic [15:0] OTG_POWER_CONTROL_OFS   = 16'hC098;
	localparam logic [15:0] BOOT_STATUS_OFS         = 16'hC0F0;
	localparam logic [15:0] USB_CTRL_A_OFS          = 16'hC090;
	localparam logic [15:0] USB_CTRL_B_OFS          = 16'hC0B0;

	// ==========================================================
	// reset values
	localparam logic [15:0] CPU_CLOCK_DIVIDER_RST   = 16'h0000;
	localparam logic [15:0] POWER_SLEEP_CONTROL_RST = 16'h0000;
	localparam logic [15:0] OTG_POWER_CONTROL_RST   = 16'h0000;
	localparam logic [15:0] USB_CTRL_RST            = 16'h0000;

	// ==========================================================
	// field positions
	localparam int SLEEP_EN_BIT     = 1;
	localparam int WAKE_USB_BIT     = 2;
	localparam int WAKE_VBUS_BIT    = 3;
	localparam int WAKE_ID_BIT      = 4;
	localparam int WAKE_PORT_BIT    = 5;
	localparam int WAKE_EXTERNAL_IRQ_ONE_BIT    = 6;
	localparam int WAKE_EXTERNAL_IRQ_ZERO_BIT    = 7;
	localparam int CHARGE_PUMP_BIT  = 0;
	localparam int CPU_DIV_W        = 4;

	// ==========================================================
	// timing
	localparam int CLK_MHZ          = 250;
	localparam int SYNC_SETTLE      = 4;
	localparam int BOOT_TIME_US     = 3000;
	localparam int BOOT_CYCLES      = BOOT_TIME_US * CLK_MHZ;
	localparam int PLL_TIME_US      = 200;
	localparam int PLL_CYCLES       = PLL_TIME_US * CLK_MHZ;
	localparam int FETCH_TIME_US    = 200;
	localparam int FETCH_CYCLES     = FETCH_TIME_US * CLK_MHZ;
	localparam int RST_MIN_XTAL     = 16;
	localparam int XTAL_MHZ         = 12;
	localparam int RST_MIN_CYCLES   = (RST_MIN_XTAL * CLK_MHZ + XTAL_MHZ - 1) / XTAL_MHZ;
	localparam logic [15:0] RESET_VECTOR = 16'hFF00;
	localparam logic [15:0] BOOT_START   = 16'hE000;
	localparam logic [15:0] DUMMY_DATA   = 16'h0000;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		BSRC_BOOT_HOST_PORT = 2'b00,
		BSRC_BOOT_FAST_SER  = 2'b01,
		BSRC_BOOT_SPI_SLAVE = 2'b10,
		BSRC_BOOT_EEPROM    = 2'b11
	} bsrc_boot_t;

	typedef struct packed {
		logic port_read;
		logic usb_resume;
		logic bus_power;
		logic identity;
		logic irq_one;
		logic irq_zero;
	} bsrc_wake_t;

	typedef struct packed {
		logic crystal_drive;
		logic pll_on;
		logic booster_on;
		logic transceiver_on;
		logic cpu_run;
		logic mem_addr_low;
	} bsrc_power_t;

endpackage : bsrc_pkg

// ===== src/bsrc_top.sv
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
module bsrc_top #(
	parameter int BOOT_CNT  = bsrc_pkg::BOOT_CYCLES,
	parameter int PLL_CNT   = bsrc_pkg::PLL_CYCLES,
	parameter int FETCH_CNT = bsrc_pkg::FETCH_CYCLES
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 reset_in_low,
	input  wire logic                 usb_bus_reset,
	input  wire logic [1:0]           boot_pin_in,
	output logic      [1:0]           boot_pin_out,
	output logic      [1:0]           boot_pin_oe,
	input  wire logic                 clock_source_select_pin,
	input  wire logic                 otg_identity_pin,
	input  wire logic                 otg_bus_power_pin,
	input  wire logic                 usb_resume_in,
	input  wire logic                 external_irq_one,
	input  wire logic                 external_irq_zero,
	input  wire logic                 port_read_strobe,
	output logic      [15:0]          port_read_data,
	output logic      [2:0]           coproc_port_en,
	output logic                      debug_uart_en,
	output logic                      otg_capable_port_host,
	output logic      [2:0]           other_ports_host,
	output logic                      boot_done,
	output logic                      load_enable,
	output logic                      fetch_start,
	output logic      [15:0]          fetch_addr,
	output logic                      cpu_clk_en,
	output bsrc_pkg::bsrc_power_t     power,
	output logic                      charge_pump_on,
	output logic                      clk_sel_12mhz,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [15:0]          wb_adr_i,
	input  wire logic [1:0]           wb_sel_i,
	input  wire logic [15:0]          wb_dat_i,
	output logic      [15:0]          wb_dat_o,
	output logic                      wb_ack_o
);
	import bsrc_pkg::*;

	typedef enum logic [3:0] {
		ST_RESET = 4'b0001,
		ST_BOOT  = 4'b0010,
		ST_RUN   = 4'b0100,
		ST_SLEEP = 4'b1000
	} bsrc_state_t;

	// ==========================================================
	// pin synchronisers: three flops, change when last two agree
	logic [8:0] s1_reg, s2_reg, s3_reg, pin_reg;
	logic [8:0] pins_raw;
	assign pins_raw = {reset_in_low, boot_pin_in, clock_source_select_pin,
		otg_identity_pin, external_irq_one, external_irq_zero, otg_bus_power_pin, usb_resume_in};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_reg  <= 9'h100;
			s2_reg  <= 9'h100;
			s3_reg  <= 9'h100;
			pin_reg <= 9'h100;
		end else begin
			s1_reg <= pins_raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < 9; i++) begin
				if (s2_reg[i] == s3_reg[i])
					pin_reg[i] <= s3_reg[i];
			end
		end
	end

	logic pin_rst_n, pin_boot1, pin_boot0, pin_clock_source_select_pin, pin_id, pin_external_irq_one, pin_external_irq_zero, pin_vbus, pin_resume;
	assign {pin_rst_n, pin_boot1, pin_boot0, pin_clock_source_select_pin, pin_id, pin_external_irq_one, pin_external_irq_zero, pin_vbus, pin_resume} = pin_reg;

	// ==========================================================
	// reset pin qualification
	localparam int RW = $clog2(RST_MIN_CYCLES + 1);
	logic [RW-1:0] low_cnt_reg;
	logic          pin_reset;
	always_ff @(posedge clk) begin
		if (!rst_n)
			low_cnt_reg <= '0;
		else if (pin_rst_n)
			low_cnt_reg <= '0;
		else if (low_cnt_reg != RW'(RST_MIN_CYCLES))
			low_cnt_reg <= low_cnt_reg + 1'b1;
	end
	// shorter glitches are not a reset; held level keeps it
	assign pin_reset = !pin_rst_n && (low_cnt_reg == RW'(RST_MIN_CYCLES));
	logic soft_rst;
	assign soft_rst = !rst_n || pin_reset;

	// ==========================================================
	// state machine
	bsrc_state_t   state_reg;
	logic [31:0]   cnt_reg;
	logic [31:0]   fetch_cnt_reg;
	logic [15:0]   power_reg;
	logic [1:0]    boot_mode_reg;
	logic          wake_now;

	always_ff @(posedge clk) begin
		if (soft_rst) begin
			state_reg <= ST_RESET;
			cnt_reg   <= '0;
		end else begin
			unique case (state_reg)
				// hold until straps have passed the pin synchronisers
				ST_RESET: begin
					if (cnt_reg >= 32'(SYNC_SETTLE)) begin
						state_reg <= ST_BOOT;
						cnt_reg   <= '0;
					end else
						cnt_reg <= cnt_reg + 32'h1;
				end
				ST_BOOT: begin
					if (cnt_reg >= 32'(BOOT_CNT - 1))
						state_reg <= ST_RUN;
					else
						cnt_reg <= cnt_reg + 32'h1;
				end
				ST_RUN: begin
					if (power_reg[SLEEP_EN_BIT])
						state_reg <= ST_SLEEP;
					cnt_reg <= '0;
				end
				ST_SLEEP: begin
					if (wake_now) begin
						state_reg <= ST_RUN;
					end
				end
			endcase
		end
	end

	// boot straps sampled on every cycle of ST_RESET; the last sample is kept
	always_ff @(posedge clk) begin
		if (soft_rst) begin
			boot_mode_reg <= 2'h0;
			clk_sel_12mhz <= 1'b0;
		end else if (state_reg == ST_RESET) begin
			boot_mode_reg <= {pin_boot1, pin_boot0};
			clk_sel_12mhz <= pin_clock_source_select_pin;
		end
	end

	// ==========================================================
	// pin roles from ST_BOOT on
	logic standalone;
	assign standalone = (boot_mode_reg == BSRC_BOOT_EEPROM);
	always_ff @(posedge clk) begin
		if (soft_rst) begin
			coproc_port_en        <= 3'h0;
			debug_uart_en         <= 1'b0;
			boot_pin_oe           <= 2'h0;
			boot_pin_out          <= 2'h0;
			otg_capable_port_host <= 1'b0;
			other_ports_host      <= 3'h0;
			boot_done             <= 1'b0;
			load_enable           <= 1'b0;
		end else if (state_reg != ST_RESET) begin
			boot_done <= (state_reg == ST_RUN) || (state_reg == ST_SLEEP);
			unique case (boot_mode_reg)
				BSRC_BOOT_HOST_PORT: coproc_port_en <= 3'b001;
				BSRC_BOOT_FAST_SER:  coproc_port_en <= 3'b010;
				BSRC_BOOT_SPI_SLAVE: coproc_port_en <= 3'b100;
				BSRC_BOOT_EEPROM:    coproc_port_en <= 3'b000;
			endcase
			// load gate opens only once the boot interval ends
			load_enable <= (state_reg == ST_RUN);
			debug_uart_en <= standalone;
			boot_pin_oe   <= (standalone && state_reg != ST_BOOT) ? 2'b11 : 2'b00;
			boot_pin_out  <= 2'b11; // eeprom lines idle high
			otg_capable_port_host <= standalone && !pin_id;
			other_ports_host      <= 3'h0;
		end
	end

	// ==========================================================
	// wakeup detection
	logic id_d_reg, external_irq_one_d_reg, external_irq_zero_d_reg;
	always_ff @(posedge clk) begin
		if (soft_rst) begin
			// follow the pins so reset makes no false edge
			id_d_reg   <= pin_id;
			external_irq_one_d_reg <= pin_external_irq_one;
			external_irq_zero_d_reg <= pin_external_irq_zero;
		end else begin
			id_d_reg   <= pin_id;
			external_irq_one_d_reg <= pin_external_irq_one;
			external_irq_zero_d_reg <= pin_external_irq_zero;
		end
	end

	bsrc_wake_t wake;
	assign wake.port_read  = port_read_strobe  & power_reg[WAKE_PORT_BIT];
	assign wake.usb_resume = pin_resume         & power_reg[WAKE_USB_BIT];
	assign wake.bus_power  = pin_vbus           & power_reg[WAKE_VBUS_BIT];
	assign wake.identity   = (pin_id ^ id_d_reg) & power_reg[WAKE_ID_BIT];
	assign wake.irq_one    = (pin_external_irq_one ^ external_irq_one_d_reg) & power_reg[WAKE_EXTERNAL_IRQ_ONE_BIT];
	assign wake.irq_zero   = (pin_external_irq_zero ^ external_irq_zero_d_reg) & power_reg[WAKE_EXTERNAL_IRQ_ZERO_BIT];
	assign wake_now = |wake;

	// read strobe during sleep answers dummy data
	always_ff @(posedge clk) begin
		if (soft_rst)
			port_read_data <= DUMMY_DATA;
		else if (port_read_strobe && state_reg == ST_SLEEP)
			port_read_data <= DUMMY_DATA;
		else if (port_read_strobe)
			port_read_data <= power_reg;
	end

	// ==========================================================
	// power outputs and pll settle
	logic [31:0] pll_cnt_reg;
	logic        pll_ok;
	always_ff @(posedge clk) begin
		if (soft_rst)
			pll_cnt_reg <= '0;
		else if (state_reg == ST_SLEEP)
			pll_cnt_reg <= '0;
		else if (pll_cnt_reg < 32'(PLL_CNT))
			pll_cnt_reg <= pll_cnt_reg + 32'h1;
	end
	assign pll_ok = (pll_cnt_reg == 32'(PLL_CNT));

	always_ff @(posedge clk) begin
		if (soft_rst) begin
			power <= '{crystal_drive: 1'b1, pll_on: 1'b1, booster_on: 1'b1,
				transceiver_on: 1'b1, cpu_run: 1'b0, mem_addr_low: 1'b0};
		end else begin
			power.crystal_drive  <= (state_reg != ST_SLEEP);
			power.pll_on         <= (state_reg != ST_SLEEP);
			power.booster_on     <= (state_reg != ST_SLEEP);
			power.transceiver_on <= (state_reg != ST_SLEEP);
			// gpio config lives outside; only address bus forced
			power.mem_addr_low   <= (state_reg == ST_SLEEP);
			power.cpu_run        <= (state_reg == ST_RUN) && pll_ok && fetch_start;
		end
	end

	// ==========================================================
	// first instruction fetch
	always_ff @(posedge clk) begin
		if (soft_rst) begin
			fetch_cnt_reg <= '0;
			fetch_start   <= 1'b0;
			fetch_addr    <= RESET_VECTOR;
		end else if (state_reg != ST_RESET) begin
			if (fetch_cnt_reg < 32'(FETCH_CNT))
				fetch_cnt_reg <= fetch_cnt_reg + 32'h1;
			else if (!fetch_start) begin
				fetch_start <= 1'b1;
				fetch_addr  <= RESET_VECTOR;
			end else
				fetch_addr <= BOOT_START;
		end
	end

	// ==========================================================
	// cpu clock divider: cpu only, peripherals keep base rate
	logic [15:0]          div_reg;
	logic [CPU_DIV_W-1:0] div_cnt_reg;
	always_ff @(posedge clk) begin
		if (soft_rst) begin
			div_cnt_reg <= '0;
			cpu_clk_en  <= 1'b0;
		end else if (div_cnt_reg >= div_reg[CPU_DIV_W-1:0]) begin
			div_cnt_reg <= '0;
			cpu_clk_en  <= power.cpu_run;
		end else begin
			div_cnt_reg <= div_cnt_reg + 1'b1;
			cpu_clk_en  <= 1'b0;
		end
	end

	// ==========================================================
	// wishbone slave: ack one cycle after request, then drop
	logic [15:0] otg_reg, usb_a_reg, usb_b_reg;
	logic        wb_req, wb_wr;
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr  = wb_req && wb_we_i;

	function automatic logic [15:0] bsrc_merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] sel);
		return {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
	endfunction : bsrc_merge

	always_ff @(posedge clk) begin
		if (soft_rst) begin
			div_reg <= CPU_CLOCK_DIVIDER_RST;
			otg_reg <= OTG_POWER_CONTROL_RST;
		end else if (wb_wr && wb_adr_i == CPU_CLOCK_DIVIDER_OFS)
			div_reg <= bsrc_merge(div_reg, wb_dat_i, wb_sel_i);
		else if (wb_wr && wb_adr_i == OTG_POWER_CONTROL_OFS)
			otg_reg <= bsrc_merge(otg_reg, wb_dat_i, wb_sel_i);
	end

	// sleep bit clears itself on wake so firmware does not re-enter
	always_ff @(posedge clk) begin
		if (soft_rst)
			power_reg <= POWER_SLEEP_CONTROL_RST;
		else if (wb_wr && wb_adr_i == POWER_SLEEP_CONTROL_OFS)
			power_reg <= bsrc_merge(power_reg, wb_dat_i, wb_sel_i);
		else if (state_reg == ST_SLEEP && wake_now)
			power_reg[SLEEP_EN_BIT] <= 1'b0;
	end

	// usb bus reset hits only these two
	always_ff @(posedge clk) begin
		if (soft_rst || usb_bus_reset) begin
			usb_a_reg <= USB_CTRL_RST;
			usb_b_reg <= USB_CTRL_RST;
		end else if (wb_wr && wb_adr_i == USB_CTRL_A_OFS)
			usb_a_reg <= bsrc_merge(usb_a_reg, wb_dat_i, wb_sel_i);
		else if (wb_wr && wb_adr_i == USB_CTRL_B_OFS)
			usb_b_reg <= bsrc_merge(usb_b_reg, wb_dat_i, wb_sel_i);
	end

	always_ff @(posedge clk) begin
		if (soft_rst)
			charge_pump_on <= 1'b0;
		else
			charge_pump_on <= otg_reg[CHARGE_PUMP_BIT];
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 16'h0000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				unique case (wb_adr_i)
					CPU_CLOCK_DIVIDER_OFS:   wb_dat_o <= div_reg;
					POWER_SLEEP_CONTROL_OFS: wb_dat_o <= power_reg;
					OTG_POWER_CONTROL_OFS:   wb_dat_o <= otg_reg;
					USB_CTRL_A_OFS:          wb_dat_o <= usb_a_reg;
					USB_CTRL_B_OFS:          wb_dat_o <= usb_b_reg;
					BOOT_STATUS_OFS:         wb_dat_o <= {11'h000, boot_done, clk_sel_12mhz,
						state_reg == ST_SLEEP, boot_mode_reg};
					default:                 wb_dat_o <= 16'h0000;
				endcase
			end
		end
	end

endmodule : bsrc_top

`default_nettype wire

// ===== verif/bsrc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// boot and sleep checker
module bsrc_monitor #(
	parameter int PLL_CNT = 30
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic [1:0]            boot_pin_oe,
	input  wire logic [2:0]            coproc_port_en,
	input  wire logic                  debug_uart_en,
	input  wire logic                  otg_capable_port_host,
	input  wire logic                  boot_done,
	input  wire logic                  load_enable,
	input  wire logic                  fetch_start,
	input  wire logic [15:0]           fetch_addr,
	input  wire bsrc_pkg::bsrc_power_t power
);
	import bsrc_pkg::*;
	// slack of 6 cycles over the PLL_CNT cycles from pll_on rising to cpu_run
	localparam int PLL_LIM = PLL_CNT + 6;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_vector;
		fetch_addr == RESET_VECTOR;
	endsequence
	sequence s_jump;
		fetch_start && fetch_addr == BOOT_START;
	endsequence
	AST_SLEEP_OFF: assert property (!power.pll_on |-> !power.crystal_drive && !power.booster_on && !power.transceiver_on)
		else $error("power stage on while pll off");
	AST_SLEEP_ADDR: assert property (power.mem_addr_low |-> !power.pll_on && !power.cpu_run)
		else $error("address low outside sleep");
	AST_CPU_HALT: assert property (power.cpu_run |-> power.pll_on && fetch_start)
		else $error("cpu runs without pll");
	AST_LOAD_AFTER_BOOT: assert property (load_enable |-> boot_done)
		else $error("load before boot end");
	AST_PINS_IDLE: assert property (!boot_done |-> boot_pin_oe == 2'b00)
		else $error("boot pins driven during boot");
	AST_STANDALONE_PINS: assert property (boot_done && $past(boot_done) && debug_uart_en |-> boot_pin_oe == 2'b11)
		else $error("standalone pins not driven");
	AST_ONE_PORT: assert property (boot_done && $past(boot_done) |-> ($countones(coproc_port_en) == 1) != debug_uart_en)
		else $error("port enable count wrong");
	AST_OTG_ROLE: assert property (otg_capable_port_host |-> debug_uart_en)
		else $error("otg host role outside standalone");
	AST_FETCH_VECTOR: assert property ($rose(fetch_start) |-> s_vector ##1 s_jump)
		else $error("fetch vector order wrong");
	AST_WAKE_RESUME: assert property ($rose(power.pll_on) && fetch_start |-> ##[1:PLL_LIM] power.cpu_run)
		else $error("cpu not resumed in time");
endmodule : bsrc_monitor
bind bsrc_top bsrc_monitor #(.PLL_CNT(PLL_CNT)) bsrc_monitor_inst (.clk, .rst_n, .boot_pin_oe, .coproc_port_en,
	.debug_uart_en, .otg_capable_port_host, .boot_done, .load_enable, .fetch_start, .fetch_addr, .power);
`default_nettype wire

// ===== verif/bsrc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// external host: straps, reset pin, wake reads
module bsrc_host_model (
	input  wire logic        clk,
	input  wire logic [1:0]  strap,
	input  wire logic        reset_req,
	input  wire logic        read_req,
	input  wire logic [1:0]  boot_pin_out,
	input  wire logic [1:0]  boot_pin_oe,
	input  wire logic [15:0] port_read_data,
	output logic      [1:0]  boot_pin_in,
	output logic             reset_in_low,
	output logic             port_read_strobe,
	output logic      [15:0] read_word
);
	import bsrc_pkg::*;
	int   rst_cnt = 0;
	logic rd_d    = 1'b0;
	initial begin
		port_read_strobe = 1'b0;
		read_word = 16'hFFFF;
	end
	// released pins fall to the strap resistors
	assign boot_pin_in = (boot_pin_oe & boot_pin_out) | (~boot_pin_oe & strap);
	assign reset_in_low = (rst_cnt == 0);
	always @(posedge clk) begin
		if (reset_req && rst_cnt == 0) begin
			rst_cnt <= RST_MIN_CYCLES + 8;
		end else if (rst_cnt != 0) begin
			rst_cnt <= rst_cnt - 1;
		end
		port_read_strobe <= read_req;
		rd_d <= port_read_strobe;
		if (rd_d) begin
			read_word <= port_read_data;
		end
	end
endmodule : bsrc_host_model
`default_nettype wire

// ===== verif/bsrc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bsrc_tb_top;
	import bsrc_pkg::*;
	localparam int PLL_N = 30;
	logic        clk, rst_n = 0, usb_bus_reset = 0, clock_source_select_pin = 1, otg_identity_pin = 0;
	logic        otg_bus_power_pin = 0, usb_resume_in = 0, external_irq_one = 0, external_irq_zero = 0;
	logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, reset_req = 0, read_req = 0;
	logic [1:0]  wb_sel_i = 0, strap = 0, boot_pin_in, boot_pin_out, boot_pin_oe;
	logic [15:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o, port_read_data, fetch_addr, read_word;
	logic [2:0]  coproc_port_en, other_ports_host;
	logic        reset_in_low, port_read_strobe, debug_uart_en, otg_capable_port_host, boot_done, load_enable;
	logic        fetch_start, cpu_clk_en, charge_pump_on, clk_sel_12mhz, wb_ack_o;
	bsrc_power_t power;
	int          seed = 23, mismatches = 0, check_count = 0, mdl[int];
	int          msk[int] = '{16'hC008: 'hF, 16'hC00A: 'hFFFF, 16'hC098: 1, 16'hC090: 'hFFFF, 16'hC0B0: 'hFFFF,
		16'hC0F0: 'h1F};
	logic [15:0] regs[6] = '{16'hC008, 16'hC00A, 16'hC098, 16'hC090, 16'hC0B0, 16'hC0A0};

	bsrc_top #(.BOOT_CNT(40), .PLL_CNT(PLL_N), .FETCH_CNT(60)) bsrc_top_inst (.clk, .rst_n, .reset_in_low,
		.usb_bus_reset, .boot_pin_in, .boot_pin_out, .boot_pin_oe, .clock_source_select_pin, .otg_identity_pin,
		.otg_bus_power_pin, .usb_resume_in, .external_irq_one, .external_irq_zero, .port_read_strobe,
		.port_read_data, .coproc_port_en, .debug_uart_en, .otg_capable_port_host, .other_ports_host, .boot_done,
		.load_enable, .fetch_start, .fetch_addr, .cpu_clk_en, .power, .charge_pump_on, .clk_sel_12mhz, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
	bsrc_host_model bsrc_host_model_inst (.clk, .strap, .reset_req, .read_req, .boot_pin_out, .boot_pin_oe,
		.port_read_data, .boot_pin_in, .reset_in_low, .port_read_strobe, .read_word);

	// ==========
	// checks and bus tasks
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wb(input logic we, input logic [15:0] adr, input logic [15:0] dat, input logic [1:0] sel,
		output logic [15:0] rd);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= sel;
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	task automatic wr(input logic [15:0] adr, input logic [15:0] dat, input logic [1:0] sel);
		logic [15:0] d;
		wb(1'b1, adr, dat, sel, d);
		d = mdl.exists(adr) ? 16'(mdl[adr]) : 16'h0000;
		// unmapped places swallow writes
		if (msk.exists(adr)) begin
			mdl[adr] = {sel[1] ? dat[15:8] : d[15:8], sel[0] ? dat[7:0] : d[7:0]};
		end
	endtask : wr
	task automatic rd(input logic [15:0] adr);
		logic [15:0] d, m, e;
		wb(1'b0, adr, 16'h0000, 2'b11, d);
		m = msk.exists(adr) ? 16'(msk[adr]) : 16'hFFFF;
		e = mdl.exists(adr) ? 16'(mdl[adr]) : 16'h0000;
		chk("read data", e & m, d & m);
	endtask : rd
	task automatic wait_run(input int lim);
		int n;
		n = 0;
		while (!(load_enable === 1'b1 && power.cpu_run === 1'b1) && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_run

	// ==========
	// clock, watchdog, scenarios
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#(4 * 40000);
		mismatches++;
		end_sim();
	end
	initial begin
		int m, n;
		logic cs;
		logic [15:0] d;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (m = 3; m >= 0; m--) begin
			wr(16'hC090, 16'($random(seed)), 2'b11);
			cs = 1'($random(seed));
			strap <= m[1:0];
			clock_source_select_pin <= cs;
			reset_req <= 1'b1;
			@(posedge clk);
			reset_req <= 1'b0;
			mdl.delete();
			@(posedge reset_in_low);
			wait_run(1500);
			d = (m == 3) ? 16'h0000 : 16'(1 << m);
			chk("port enable", d, {13'h0, coproc_port_en});
			chk("uart", {15'h0, m == 3}, {15'h0, debug_uart_en});
			chk("pin drive", (m == 3) ? 16'h0003 : 16'h0000, {14'h0, boot_pin_oe});
			chk("clock select", {15'h0, cs}, {15'h0, clk_sel_12mhz});
			chk("fetch", 16'hE000, fetch_addr);
			strap <= ~m[1:0];
			repeat (8) @(posedge clk);
			mdl[16'hC0F0] = 'h10 | (cs << 3) | m;
			rd(16'hC0F0);
			rd(16'hC090);
			if (m == 3) begin
				chk("eeprom lines", 16'h0003, {14'h0, boot_pin_out});
				chk("other ports", 16'h0000, {13'h0, other_ports_host});
				otg_identity_pin <= 1'b0;
				repeat (6) @(posedge clk);
				chk("otg host", 16'h0001, {15'h0, otg_capable_port_host});
				otg_identity_pin <= 1'b1;
				repeat (6) @(posedge clk);
				chk("otg host", 16'h0000, {15'h0, otg_capable_port_host});
			end
		end
		for (int i = 0; i < 6; i++) begin
			wr(regs[i], 16'($random(seed)) & 16'hFFFD, 2'($random(seed)));
		end
		repeat (2) @(posedge clk);
		chk("charge pump", 16'(mdl[16'hC098] & 1), {15'h0, charge_pump_on});
		usb_bus_reset <= 1'b1;
		@(posedge clk);
		usb_bus_reset <= 1'b0;
		mdl[16'hC090] = 0;
		mdl[16'hC0B0] = 0;
		foreach (regs[i]) rd(regs[i]);
		wr(16'hC008, 16'h0003, 2'b11);
		@(posedge clk iff cpu_clk_en === 1'b1);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cpu_clk_en !== 1'b1 && n < 40);
		chk("cpu clock gap", 16'h0004, 16'(n));
		// sources: usb resume, bus power, id edge, port read, irq one, irq zero
		for (int i = 0; i < 6; i++) begin
			wr(16'hC00A, 16'(1 << (i + 2)) | 16'h0002, 2'b11);
			repeat (3) @(posedge clk);
			chk("pll", 16'h0000, {15'h0, power.pll_on});
			chk("address low", 16'h0001, {15'h0, power.mem_addr_low});
			if (i != 5) external_irq_zero <= ~external_irq_zero;
			else external_irq_one <= ~external_irq_one;
			repeat (10) @(posedge clk);
			chk("still asleep", 16'h0000, {15'h0, power.cpu_run});
			case (i)
				0: usb_resume_in <= 1'b1;
				1: otg_bus_power_pin <= 1'b1;
				2: otg_identity_pin <= ~otg_identity_pin;
				3: read_req <= 1'b1;
				4: external_irq_one <= ~external_irq_one;
				default: external_irq_zero <= ~external_irq_zero;
			endcase
			@(posedge clk);
			read_req <= 1'b0;
			wait_run(PLL_N + 12);
			chk("resumed", 16'h0001, {15'h0, power.cpu_run});
			usb_resume_in <= 1'b0;
			otg_bus_power_pin <= 1'b0;
			if (i == 3) chk("wake read", 16'h0000, read_word);
			// sleep bit clears itself on wake, enables stay
			mdl[16'hC00A] = 1 << (i + 2);
			rd(16'hC00A);
		end
		end_sim();
	end
endmodule : bsrc_tb_top
`default_nettype wire
